// ===== inc/rci_pkg.sv
// Purpose: Shared constants for the radio core interrupt combiner and
//          the paged radio data RAM map.
// Assumes: Byte-wide external data space, 16-bit addresses.
// Notes:   Register offsets are absolute external data addresses.
package rci_pkg;
	localparam int        RAM_BYTES   = 1024;
	localparam int        PAGE_BYTES  = 128;
	localparam int        PAGES       = 8;
	localparam int        RAM_AW      = 10;
	localparam logic [7:0] FIFO_DEPTH = 8'h80;
	localparam logic [2:0] PAGE_RX    = 3'h6;
	localparam logic [2:0] PAGE_TX    = 3'h7;
	// Pages 0, 1, 6, 7 keep contents in every power mode
	localparam logic [7:0] RETAIN_MASK = 8'hC3;

	// External data space windows
	localparam logic [6:0] WIN_HI     = 7'h30;
	localparam logic [1:0] WIN_SEL    = 2'h0;
	localparam logic [1:0] WIN_RX     = 2'h1;
	localparam logic [1:0] WIN_TX     = 2'h2;
	localparam logic [15:0] REG_FIRST = 16'h6180;
	localparam logic [15:0] REG_LAST  = 16'h61F7;

	// Core registers
	localparam logic [15:0] REG_EVT_FLAGS_A = 16'h6180;
	localparam logic [15:0] REG_EVT_FLAGS_B = 16'h6181;
	localparam logic [15:0] REG_ERR_FLAGS   = 16'h6182;
	localparam logic [15:0] REG_EVT_MASK_A  = 16'h6183;
	localparam logic [15:0] REG_EVT_MASK_B  = 16'h6184;
	localparam logic [15:0] REG_ERR_MASK    = 16'h6185;
	localparam logic [15:0] REG_RAM_CFG     = 16'h6186;
	localparam logic [15:0] REG_CPU_IRQ     = 16'h6187;
	localparam logic [15:0] REG_FIFO_DATA   = 16'h6188;
	localparam logic [15:0] REG_RX_LEN      = 16'h6189;
	localparam logic [15:0] REG_TX_LEN      = 16'h618A;

	// Error flag bit positions
	localparam int ERR_RX_OVF = 0;
	localparam int ERR_RX_UNF = 1;
	localparam int ERR_TX_OVF = 2;
	localparam int ERR_TX_UNF = 3;
	// CPU-level register bit positions
	localparam int CPU_ERR_EN   = 0;
	localparam int CPU_EVT_EN   = 1;
	localparam int CPU_ERR_FLAG = 2;
	localparam int CPU_EVT_FLAG = 3;
	// CPU interrupt vectors of the two request lines
	localparam logic [4:0] VEC_ERR = 5'h00;
	localparam logic [4:0] VEC_EVT = 5'h0C;

	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic [2:0] RST_PAGE  = 3'h0;
endpackage

// ===== logic/rci_ram.sv
// Purpose: Radio data RAM, one read/write port for the CPU and one
//          write plus one read port for the radio side.
// Assumes: Port B write wins a same-address collision with port A.
// Notes:   Read data come from a register; an alternate value can be
//          loaded instead of the array byte.
`timescale 1ns/100ps
module rci_ram #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_arst_n,
	input  wire logic          i_clk_en,
	input  wire logic          i_a_we,
	input  wire logic          i_a_rd,
	input  wire logic [AW-1:0] i_a_addr,
	input  wire logic [DW-1:0] i_a_wdata,
	input  wire logic          i_a_use_ram,
	input  wire logic [DW-1:0] i_a_alt,
	output logic      [DW-1:0] o_a_rdata,
	input  wire logic          i_b_we,
	input  wire logic [AW-1:0] i_b_waddr,
	input  wire logic [DW-1:0] i_b_wdata,
	input  wire logic          i_b_rd,
	input  wire logic [AW-1:0] i_b_raddr,
	input  wire logic          i_b_use_ram,
	output logic      [DW-1:0] o_b_rdata
);
	logic [DW-1:0] mem [2**AW];

	if (AW < 1 || AW > 16 || DW < 1) begin : g_bad
		$error("rci_ram: unsupported AW or DW");
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_clk_en) begin
			if (i_a_we) begin
				mem[i_a_addr] <= i_a_wdata;
			end
			if (i_b_we) begin
				mem[i_b_waddr] <= i_b_wdata;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_a_rdata <= '0;
		end else if (i_clk_en && i_a_rd) begin
			o_a_rdata <= i_a_use_ram ? mem[i_a_addr] : i_a_alt;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_b_rdata <= '0;
		end else if (i_clk_en && i_b_rd) begin
			o_b_rdata <= i_b_use_ram ? mem[i_b_raddr] : '0;
		end
	end
endmodule

// ===== logic/rci_core.sv
// Purpose: Radio core interrupt combiner and paged data RAM mapping
//          into the CPU external data space.
// Assumes: Sources, FIFO strobes and sleep level come from logic on
//          the same clock; i_clk_en low freezes every register.
// Notes:   Flags clear by writing 0 to the bit; writing 1 keeps it.
// Overview of operation
// - Radio data RAM is 1024 bytes in eight pages of 128 bytes.
// - Pages: registers, ack buffers, MCU, sequencer, receive FIFO, transmit FIFO.
// - Page chosen by page select appears in a 128-byte window.
// - Receive FIFO page also appears at its own fixed address range.
// - Transmit FIFO page also appears at its own fixed address range.
// - CPU writes to any page are never blocked or filtered.
// - Pages 0, 1, 6, 7 retained; pages 2 to 5 lost in deep sleep.
// - Core registers sit at fixed addresses directly above the FIFO aliases.
// - Two CPU requests: error on vector 0, events on vector 12.
// - Event flags set on a rising edge of their source.
// - Each source has its own flag and mask bit in paired registers.
// - Flags update regardless of mask; mask only gates the combined request.
// - Each combined request is latched in a CPU flag and gated by enable.
// - Clearing a flag with other unmasked flags set re-raises the CPU flag.
// - Transmit and receive FIFOs are 128 bytes with hardware pointers.
// - Full-FIFO write or empty-FIFO read sets overflow or underflow flag.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module rci_core (
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_clk_en,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic [7:0]  i_evt_src_a,
	input  wire logic [7:0]  i_evt_src_b,
	input  wire logic [7:4]  i_err_src,
	input  wire logic        i_rx_push,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_tx_pop,
	output logic      [7:0]  o_tx_data,
	input  wire logic        i_deep_sleep,
	output logic             o_radio_error_interrupt,
	output logic             o_radio_event_interrupt
);
	localparam int AW = rci_pkg::RAM_AW;

	function automatic logic [AW-1:0] ram_addr(input logic [2:0] page,
		input logic [6:0] off);
		ram_addr = {page, off};
	endfunction

	function automatic logic [7:0] flag_next(input logic [7:0] q,
		input logic wr, input logic [7:0] wd, input logic [7:0] set);
		flag_next = (wr ? (q & wd) : q) | set;
	endfunction

	function automatic logic [7:0] cnt_next(input logic [7:0] c,
		input logic inc, input logic dec);
		if (inc && !dec) begin
			cnt_next = c + 8'h01;
		end else if (dec && !inc) begin
			cnt_next = c - 8'h01;
		end else begin
			cnt_next = c;
		end
	endfunction

	logic [7:0] evt_a_q, evt_b_q, err_q;
	logic [7:0] mask_a_q, mask_b_q, err_mask_q;
	logic [7:0] src_a_q, src_b_q;
	logic [7:4] err_src_q;
	logic [2:0] ram_page_select_q;
	logic       err_en_q, evt_en_q, err_pend_q, evt_pend_q;
	logic       err_comb_q, evt_comb_q, err_wr_q, evt_wr_q;
	logic [7:0] lost_q;
	logic [6:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
	logic [7:0] rx_cnt_q, tx_cnt_q;

	logic       win_hit, reg_hit, fifo_wr, fifo_rd;
	logic [2:0] win_page;
	logic       rx_push_ok, rx_pop_ok, tx_push_ok, tx_pop_ok;
	logic       rx_ovf, rx_unf, tx_ovf, tx_unf;
	logic       a_we, a_rd, a_use_ram;
	logic [AW-1:0] a_addr;
	logic [7:0] a_alt, reg_rdata, err_set;
	logic       err_comb, evt_comb;

	// Window decode: 0x6000..0x617F, selected page then fixed aliases
	always_comb begin
		win_hit = (i_addr[15:9] == rci_pkg::WIN_HI) && (i_addr[8:7] != 2'h3);
		case (i_addr[8:7])
			rci_pkg::WIN_SEL: win_page = ram_page_select_q;
			rci_pkg::WIN_RX:  win_page = rci_pkg::PAGE_RX;
			rci_pkg::WIN_TX:  win_page = rci_pkg::PAGE_TX;
			default:          win_page = ram_page_select_q;
		endcase
		reg_hit = (i_addr >= rci_pkg::REG_FIRST) &&
			(i_addr <= rci_pkg::REG_LAST);
	end

	assign fifo_wr = i_wr && (i_addr == rci_pkg::REG_FIFO_DATA);
	assign fifo_rd = i_rd && (i_addr == rci_pkg::REG_FIFO_DATA);
	assign tx_push_ok = fifo_wr && (tx_cnt_q != rci_pkg::FIFO_DEPTH);
	assign tx_ovf     = fifo_wr && (tx_cnt_q == rci_pkg::FIFO_DEPTH);
	assign rx_pop_ok  = fifo_rd && (rx_cnt_q != 8'h00);
	assign rx_unf     = fifo_rd && (rx_cnt_q == 8'h00);
	assign rx_push_ok = i_rx_push && (rx_cnt_q != rci_pkg::FIFO_DEPTH);
	assign rx_ovf     = i_rx_push && (rx_cnt_q == rci_pkg::FIFO_DEPTH);
	assign tx_pop_ok  = i_tx_pop && (tx_cnt_q != 8'h00);
	assign tx_unf     = i_tx_pop && (tx_cnt_q == 8'h00);

	always_comb begin
		case (i_addr)
			rci_pkg::REG_EVT_FLAGS_A: reg_rdata = evt_a_q;
			rci_pkg::REG_EVT_FLAGS_B: reg_rdata = evt_b_q;
			rci_pkg::REG_ERR_FLAGS:   reg_rdata = err_q;
			rci_pkg::REG_EVT_MASK_A:  reg_rdata = mask_a_q;
			rci_pkg::REG_EVT_MASK_B:  reg_rdata = mask_b_q;
			rci_pkg::REG_ERR_MASK:    reg_rdata = err_mask_q;
			rci_pkg::REG_RAM_CFG:     reg_rdata = {5'h00, ram_page_select_q};
			rci_pkg::REG_CPU_IRQ:
				reg_rdata = {4'h0, evt_pend_q, err_pend_q, evt_en_q, err_en_q};
			rci_pkg::REG_RX_LEN:      reg_rdata = rx_cnt_q;
			rci_pkg::REG_TX_LEN:      reg_rdata = tx_cnt_q;
			default:                  reg_rdata = 8'h00;
		endcase
	end

	// CPU port: window, FIFO data register or core registers
	always_comb begin
		a_we = 1'b0;
		a_rd = i_rd;
		a_use_ram = 1'b0;
		a_addr = ram_addr(win_page, i_addr[6:0]);
		a_alt = 8'h00;
		if (win_hit) begin
			a_we = i_wr;
			a_use_ram = !lost_q[win_page];
		end else if (tx_push_ok) begin
			a_we = 1'b1;
			a_addr = ram_addr(rci_pkg::PAGE_TX, tx_wp_q);
		end else if (fifo_rd) begin
			a_use_ram = rx_pop_ok;
			a_addr = ram_addr(rci_pkg::PAGE_RX, rx_rp_q);
		end else if (reg_hit) begin
			a_alt = reg_rdata;
		end
	end

	rci_ram #(
		.AW (AW),
		.DW (8)
	) u_ram (
		.i_ref_clk   (i_ref_clk),
		.i_arst_n    (i_arst_n),
		.i_clk_en    (i_clk_en),
		.i_a_we      (a_we),
		.i_a_rd      (a_rd),
		.i_a_addr    (a_addr),
		.i_a_wdata   (i_wdata),
		.i_a_use_ram (a_use_ram),
		.i_a_alt     (a_alt),
		.o_a_rdata   (o_rdata),
		.i_b_we      (rx_push_ok),
		.i_b_waddr   (ram_addr(rci_pkg::PAGE_RX, rx_wp_q)),
		.i_b_wdata   (i_rx_data),
		.i_b_rd      (i_tx_pop),
		.i_b_raddr   (ram_addr(rci_pkg::PAGE_TX, tx_rp_q)),
		.i_b_use_ram (tx_pop_ok),
		.o_b_rdata   (o_tx_data)
	);

	// FIFO pointers and fill counts
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_wp_q <= 7'h00;
			rx_rp_q <= 7'h00;
			tx_wp_q <= 7'h00;
			tx_rp_q <= 7'h00;
			rx_cnt_q <= 8'h00;
			tx_cnt_q <= 8'h00;
		end else if (i_clk_en) begin
			rx_wp_q <= rx_wp_q + 7'(rx_push_ok);
			rx_rp_q <= rx_rp_q + 7'(rx_pop_ok);
			tx_wp_q <= tx_wp_q + 7'(tx_push_ok);
			tx_rp_q <= tx_rp_q + 7'(tx_pop_ok);
			rx_cnt_q <= cnt_next(rx_cnt_q, rx_push_ok, rx_pop_ok);
			tx_cnt_q <= cnt_next(tx_cnt_q, tx_push_ok, tx_pop_ok);
		end
	end

	// Retention: volatile pages lose content while in deep sleep
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lost_q <= 8'h00;
		end else if (i_clk_en) begin
			for (int p = 0; p < rci_pkg::PAGES; p++) begin
				if (i_deep_sleep && !rci_pkg::RETAIN_MASK[p]) begin
					lost_q[p] <= 1'b1;
				end else if (a_we && win_hit && (win_page == 3'(p))) begin
					lost_q[p] <= 1'b0;
				end
			end
		end
	end

	// Configuration and masks
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mask_a_q <= rci_pkg::RST_MASK;
			mask_b_q <= rci_pkg::RST_MASK;
			err_mask_q <= rci_pkg::RST_MASK;
			ram_page_select_q <= rci_pkg::RST_PAGE;
			err_en_q <= 1'b0;
			evt_en_q <= 1'b0;
		end else if (i_clk_en && i_wr) begin
			case (i_addr)
				rci_pkg::REG_EVT_MASK_A: mask_a_q <= i_wdata;
				rci_pkg::REG_EVT_MASK_B: mask_b_q <= i_wdata;
				rci_pkg::REG_ERR_MASK:   err_mask_q <= i_wdata;
				rci_pkg::REG_RAM_CFG:    ram_page_select_q <= i_wdata[2:0];
				rci_pkg::REG_CPU_IRQ: begin
					err_en_q <= i_wdata[rci_pkg::CPU_ERR_EN];
					evt_en_q <= i_wdata[rci_pkg::CPU_EVT_EN];
				end
				default: ;
			endcase
		end
	end

	assign err_set = {i_err_src & ~err_src_q, tx_unf, tx_ovf, rx_unf, rx_ovf};

	// Source flags: edge set wins over a software clear in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			evt_a_q <= rci_pkg::RST_FLAGS;
			evt_b_q <= rci_pkg::RST_FLAGS;
			err_q <= rci_pkg::RST_FLAGS;
			src_a_q <= 8'h00;
			src_b_q <= 8'h00;
			err_src_q <= 4'h0;
		end else if (i_clk_en) begin
			src_a_q <= i_evt_src_a;
			src_b_q <= i_evt_src_b;
			err_src_q <= i_err_src;
			evt_a_q <= flag_next(evt_a_q, i_wr &&
				(i_addr == rci_pkg::REG_EVT_FLAGS_A), i_wdata,
				i_evt_src_a & ~src_a_q);
			evt_b_q <= flag_next(evt_b_q, i_wr &&
				(i_addr == rci_pkg::REG_EVT_FLAGS_B), i_wdata,
				i_evt_src_b & ~src_b_q);
			err_q <= flag_next(err_q, i_wr &&
				(i_addr == rci_pkg::REG_ERR_FLAGS), i_wdata, err_set);
		end
	end

	assign evt_comb = |(evt_a_q & mask_a_q) || |(evt_b_q & mask_b_q);
	assign err_comb = |(err_q & err_mask_q);

	// CPU-level pending flags, request lines vector 0 and vector 12
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			err_pend_q <= 1'b0;
			evt_pend_q <= 1'b0;
			err_comb_q <= 1'b0;
			evt_comb_q <= 1'b0;
			err_wr_q <= 1'b0;
			evt_wr_q <= 1'b0;
			o_radio_error_interrupt <= 1'b0;
			o_radio_event_interrupt <= 1'b0;
		end else if (i_clk_en) begin
			err_comb_q <= err_comb;
			evt_comb_q <= evt_comb;
			err_wr_q <= i_wr && (i_addr == rci_pkg::REG_ERR_FLAGS);
			evt_wr_q <= i_wr && ((i_addr == rci_pkg::REG_EVT_FLAGS_A) ||
				(i_addr == rci_pkg::REG_EVT_FLAGS_B));
			if (err_comb && (!err_comb_q || err_wr_q)) begin
				err_pend_q <= 1'b1;
			end else if (i_wr && (i_addr == rci_pkg::REG_CPU_IRQ) &&
				!i_wdata[rci_pkg::CPU_ERR_FLAG]) begin
				err_pend_q <= 1'b0;
			end
			if (evt_comb && (!evt_comb_q || evt_wr_q)) begin
				evt_pend_q <= 1'b1;
			end else if (i_wr && (i_addr == rci_pkg::REG_CPU_IRQ) &&
				!i_wdata[rci_pkg::CPU_EVT_FLAG]) begin
				evt_pend_q <= 1'b0;
			end
			o_radio_error_interrupt <= err_pend_q && err_en_q;
			o_radio_event_interrupt <= evt_pend_q && evt_en_q;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);

	property p_edge_sets_flag;
		i_clk_en && i_evt_src_a[0] && !src_a_q[0] |=> evt_a_q[0];
	endproperty
	a_edge_sets_flag: assert property (p_edge_sets_flag)
		else $error("rising source edge did not set flag");

	// Masked bit 1 of group A still records its rising edge
	property p_masked_still_sets;
		i_clk_en && !mask_a_q[1] && i_evt_src_a[1] && !src_a_q[1]
			|=> evt_a_q[1];
	endproperty
	a_masked_still_sets: assert property (p_masked_still_sets)
		else $error("masked source flag not updated");

	property p_enable_gates;
		i_clk_en && !err_en_q |=> !o_radio_error_interrupt;
	endproperty
	a_enable_gates: assert property (p_enable_gates)
		else $error("error request raised while disabled");

	property p_request_follows;
		i_clk_en && evt_pend_q && evt_en_q |=> o_radio_event_interrupt;
	endproperty
	a_request_follows: assert property (p_request_follows)
		else $error("event request not raised for pending flag");

	property p_rearm;
		i_clk_en && evt_wr_q && evt_comb |=> evt_pend_q;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("pending flag not set again after clear");

	property p_tx_overflow;
		i_clk_en && fifo_wr && tx_cnt_q == 8'h80
			|=> err_q[rci_pkg::ERR_TX_OVF] &&
			tx_cnt_q == ($past(i_tx_pop) ? 8'h7F : 8'h80);
	endproperty
	a_tx_overflow: assert property (p_tx_overflow)
		else $error("write to full FIFO not flagged");

	property p_rx_underflow;
		i_clk_en && fifo_rd && rx_cnt_q == 8'h00
			|=> o_rdata == 8'h00 && err_q[rci_pkg::ERR_RX_UNF];
	endproperty
	a_rx_underflow: assert property (p_rx_underflow)
		else $error("read of empty FIFO not flagged or not zero");

	property p_tx_count;
		i_clk_en && tx_push_ok && !tx_pop_ok
			|=> tx_cnt_q == $past(tx_cnt_q) + 8'h01;
	endproperty
	a_tx_count: assert property (p_tx_count)
		else $error("transmit fill count did not advance");

	property p_window_write;
		i_wr && win_hit |-> a_we && a_addr[6:0] == i_addr[6:0];
	endproperty
	a_window_write: assert property (p_window_write)
		else $error("window write was blocked");

	property p_retained;
		(lost_q & rci_pkg::RETAIN_MASK) == 8'h00;
	endproperty
	a_retained: assert property (p_retained)
		else $error("retained page marked lost");

	property p_alias_rx;
		i_addr[15:7] == 9'h0C1 |-> a_addr[9:7] == rci_pkg::PAGE_RX;
	endproperty
	a_alias_rx: assert property (p_alias_rx)
		else $error("receive alias maps to wrong page");

	c_evt_irq: cover property (i_clk_en && o_radio_event_interrupt);
	c_err_irq: cover property (i_clk_en && o_radio_error_interrupt);
	c_rearm: cover property (evt_wr_q && evt_comb && i_clk_en);
	c_tx_full: cover property (tx_cnt_q == 8'h80);
endmodule

// ===== tb/rci_cpu_model.sv
// Purpose: CPU-side interrupt controller model facing the radio core.
// Assumes: Both request lines are levels on the same clock.
// Notes:   Records the vector of the most recent request entry.
`timescale 1ns/100ps
module rci_cpu_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_err_irq,
	input  wire logic       i_evt_irq,
	output logic      [4:0] o_vector,
	output logic      [7:0] o_entries
);
	logic err_q;
	logic evt_q;

	// A request is entered once per rising level; error wins a tie
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			err_q     <= 1'b0;
			evt_q     <= 1'b0;
			o_vector  <= 5'h1F;
			o_entries <= 8'h00;
		end else begin
			err_q <= i_err_irq;
			evt_q <= i_evt_irq;
			if (i_err_irq && !err_q) begin
				o_vector  <= rci_pkg::VEC_ERR;
				o_entries <= o_entries + 8'h01;
			end else if (i_evt_irq && !evt_q) begin
				o_vector  <= rci_pkg::VEC_EVT;
				o_entries <= o_entries + 8'h01;
			end
		end
	end
endmodule

// ===== tb/tb_rci_core.sv
// Purpose: Self-checking bench for the interrupt combiner and RAM map.
// Assumes: Bus strobes are driven by non-blocking assignment at edges.
// Notes:   The bench acts as software and as the radio-side FIFO user.
`timescale 1ns/100ps
module tb_rci_core;
	logic        i_ref_clk;
	logic        i_arst_n;
	logic        i_clk_en;
	logic [15:0] i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic [7:0]  i_evt_src_a;
	logic [7:0]  i_evt_src_b;
	logic [7:4]  i_err_src;
	logic        i_rx_push;
	logic [7:0]  i_rx_data;
	logic        i_tx_pop;
	logic [7:0]  o_tx_data;
	logic        i_deep_sleep;
	logic        o_err_irq;
	logic        o_evt_irq;
	logic [4:0]  vec;
	logic [7:0]  entries;
	logic [7:0]  rd_val;
	logic [7:0]  seed;
	logic [6:0]  offs [0:15];
	logic [7:0]  dats [0:15];
	int          mismatches;
	int          num_checks;

	rci_core dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
		.i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_evt_src_a(i_evt_src_a), .i_evt_src_b(i_evt_src_b),
		.i_err_src(i_err_src), .i_rx_push(i_rx_push),
		.i_rx_data(i_rx_data), .i_tx_pop(i_tx_pop),
		.o_tx_data(o_tx_data), .i_deep_sleep(i_deep_sleep),
		.o_radio_error_interrupt(o_err_irq),
		.o_radio_event_interrupt(o_evt_irq));
	rci_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
		.i_err_irq(o_err_irq), .i_evt_irq(o_evt_irq),
		.o_vector(vec), .o_entries(entries));

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [15:0] a);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 rd_val = o_rdata;
	endtask
	task automatic bus_chk(input string what, input logic [15:0] a,
		input logic [7:0] e);
		bus_rd(a);
		chk(what, e, rd_val);
	endtask
	task automatic settle();
		repeat (4) @(posedge i_ref_clk);
		#1;
	endtask
	// Service routine: capture, clear CPU flag, then core flags at once
	task automatic isr_err(input string what, input logic [7:0] e);
		settle();
		chk("err irq", 8'h01, {7'h00, o_err_irq});
		chk("err vector", {3'h0, rci_pkg::VEC_ERR}, {3'h0, vec});
		bus_chk(what, rci_pkg::REG_ERR_FLAGS, e);
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h03);
		bus_wr(rci_pkg::REG_ERR_FLAGS, ~e);
		settle();
		chk("err irq clear", 8'h00, {7'h00, o_err_irq});
		$display("test %s done", what);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		mismatches++;
		$display("[FAIL] watchdog expected done seen timeout");
		stop_test();
	end

	initial begin
		i_arst_n = 1'b0;
		i_clk_en = 1'b1;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_evt_src_a = 8'h00;
		i_evt_src_b = 8'h00;
		i_err_src = 4'h0;
		i_rx_push = 1'b0;
		i_rx_data = 8'h00;
		i_tx_pop = 1'b0;
		i_deep_sleep = 1'b0;
		seed = 8'h33;
		repeat (20) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		// Reset values, unmapped and read-only places
		for (int a = 0; a < 11; a++)
			bus_chk("reset reg", rci_pkg::REG_FIRST + 16'(a), 8'h00);
		// The scan popped the empty receive FIFO once
		bus_chk("scan underflow", rci_pkg::REG_ERR_FLAGS, 8'h02);
		bus_wr(rci_pkg::REG_ERR_FLAGS, 8'h00);
		bus_wr(16'h618B, 8'h5A);
		bus_wr(rci_pkg::REG_RX_LEN, 8'h12);
		bus_chk("unmapped", 16'h618B, 8'h00);
		bus_chk("ro count", rci_pkg::REG_RX_LEN, 8'h00);
		bus_chk("outside", 16'h7000, 8'h00);
		$display("test reset done");
		// Every page through the window, FIFO pages through the aliases
		for (int i = 0; i < 16; i++) begin
			seed = lfsr_next(seed);
			offs[i] = seed[6:0];
			seed = lfsr_next(seed);
			dats[i] = seed;
			bus_wr(rci_pkg::REG_RAM_CFG, 8'(i % 8));
			bus_wr(16'h6000 + 16'(offs[i]), dats[i]);
			bus_chk("page sel", rci_pkg::REG_RAM_CFG, 8'(i % 8));
			if (i % 8 == 6)
				bus_chk("rx alias", 16'h6080 + 16'(offs[i]), dats[i]);
			if (i % 8 == 7)
				bus_chk("tx alias", 16'h6100 + 16'(offs[i]), dats[i]);
		end
		for (int i = 8; i < 16; i++) begin
			bus_wr(rci_pkg::REG_RAM_CFG, 8'(i % 8));
			bus_chk("window", 16'h6000 + 16'(offs[i]), dats[i]);
		end
		bus_wr(16'h6100 + 16'(offs[3]), 8'hC4);
		bus_chk("tx window", 16'h6000 + 16'(offs[3]), 8'hC4);
		$display("test ram map done");
		// Masked flag still updates, edge, two-layer masking, re-arm
		bus_wr(rci_pkg::REG_EVT_MASK_A, 8'h01);
		bus_chk("mask a", rci_pkg::REG_EVT_MASK_A, 8'h01);
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h02);
		@(posedge i_ref_clk);
		i_evt_src_a <= 8'h02;
		settle();
		chk("masked irq", 8'h00, {7'h00, o_evt_irq});
		bus_chk("masked flag", rci_pkg::REG_EVT_FLAGS_A, 8'h02);
		@(posedge i_ref_clk);
		i_evt_src_a <= 8'h03;
		repeat (2) @(posedge i_ref_clk);
		#1 chk("evt early", 8'h00, {7'h00, o_evt_irq});
		@(posedge i_ref_clk);
		#1 chk("evt irq", 8'h01, {7'h00, o_evt_irq});
		bus_wr(rci_pkg::REG_EVT_MASK_A, 8'h03);
		chk("evt vector", {3'h0, rci_pkg::VEC_EVT}, {3'h0, vec});
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h02);
		settle();
		chk("pend clear", 8'h00, {7'h00, o_evt_irq});
		bus_wr(rci_pkg::REG_EVT_FLAGS_A, 8'hFE);
		settle();
		chk("rearm irq", 8'h01, {7'h00, o_evt_irq});
		bus_chk("rearm pend", rci_pkg::REG_CPU_IRQ, 8'h0A);
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h02);
		bus_wr(rci_pkg::REG_EVT_FLAGS_A, 8'h00);
		i_evt_src_a <= 8'h00;
		settle();
		chk("evt retired", 8'h00, {7'h00, o_evt_irq});
		bus_wr(rci_pkg::REG_EVT_MASK_B, 8'h80);
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h00);
		@(posedge i_ref_clk);
		i_evt_src_b <= 8'h80;
		settle();
		chk("gated irq", 8'h00, {7'h00, o_evt_irq});
		bus_chk("gated pend", rci_pkg::REG_CPU_IRQ, 8'h08);
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h0A);
		settle();
		chk("enabled irq", 8'h01, {7'h00, o_evt_irq});
		bus_wr(rci_pkg::REG_EVT_FLAGS_B, 8'h00);
		$display("test events done");
		// FIFO errors and data order
		bus_wr(rci_pkg::REG_ERR_MASK, 8'hFF);
		bus_wr(rci_pkg::REG_CPU_IRQ, 8'h03);
		bus_chk("underflow data", rci_pkg::REG_FIFO_DATA, 8'h00);
		isr_err("rx underflow", 8'h02);
		for (int i = 0; i < 129; i++) begin
			@(posedge i_ref_clk);
			i_rx_push <= 1'b1;
			i_rx_data <= 8'(i * 3);
		end
		@(posedge i_ref_clk);
		i_rx_push <= 1'b0;
		bus_chk("rx count", rci_pkg::REG_RX_LEN, rci_pkg::FIFO_DEPTH);
		isr_err("rx overflow", 8'h01);
		for (int i = 0; i < 128; i++)
			bus_chk("rx data", rci_pkg::REG_FIFO_DATA, 8'(i * 3));
		for (int i = 0; i < 129; i++)
			bus_wr(rci_pkg::REG_FIFO_DATA, 8'(i) ^ 8'h5A);
		bus_chk("tx count", rci_pkg::REG_TX_LEN, rci_pkg::FIFO_DEPTH);
		isr_err("tx overflow", 8'h04);
		for (int i = 0; i < 129; i++) begin
			@(posedge i_ref_clk);
			i_tx_pop <= 1'b1;
			@(posedge i_ref_clk);
			i_tx_pop <= 1'b0;
			#1 chk("tx data", (i < 128) ? 8'(i) ^ 8'h5A : 8'h00, o_tx_data);
		end
		isr_err("tx underflow", 8'h08);
		@(posedge i_ref_clk);
		i_err_src <= 4'h1;
		isr_err("extra source", 8'h10);
		i_err_src <= 4'h0;
		chk("entries", 8'h08, entries);
		// A write while the clock enable is low must not land
		i_clk_en <= 1'b0;
		bus_wr(rci_pkg::REG_ERR_MASK, 8'h00);
		i_clk_en <= 1'b1;
		bus_chk("frozen mask", rci_pkg::REG_ERR_MASK, 8'hFF);
		// Retention across deep sleep
		bus_wr(rci_pkg::REG_RAM_CFG, 8'h02);
		bus_wr(16'h6005, 8'hA5);
		bus_wr(rci_pkg::REG_RAM_CFG, 8'h00);
		bus_wr(16'h6005, 8'h3C);
		bus_wr(16'h6085, 8'h77);
		@(posedge i_ref_clk);
		i_deep_sleep <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		i_deep_sleep <= 1'b0;
		bus_chk("page 0 kept", 16'h6005, 8'h3C);
		bus_chk("page 6 kept", 16'h6085, 8'h77);
		bus_wr(rci_pkg::REG_RAM_CFG, 8'h02);
		bus_chk("page 2 lost", 16'h6005, 8'h00);
		bus_wr(16'h6005, 8'h11);
		bus_chk("page 2 again", 16'h6005, 8'h11);
		$display("test retention done");
		stop_test();
	end
endmodule
